/* File: hw/ssl_bicolour_led.sv */
// Bi-colour port LED driver from a detected signal standard
`timescale 1ns/1ps
module ssl_bicolour_led (
    input wire logic clk_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic clk_en_i, // Freezes state while low
    input wire ssl_pkg::ssl_std_type std_i, // Detected standard
    output ssl_pkg::ssl_bicolour_type led_o // Red and green dies
);
    wire logic is_3g = std_i.std_valid && (std_i.std == ssl_pkg::STD_3G);
    wire logic is_hd = std_i.std_valid && (std_i.std == ssl_pkg::STD_HD);
    wire logic is_sd = std_i.std_valid && (std_i.std == ssl_pkg::STD_SD);
    // Orange is both dies lit
    wire ssl_pkg::ssl_bicolour_type next_led = '{red: is_hd || is_sd, green: is_3g || is_hd};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            led_o <= '0;
        end else if (clk_en_i) begin
            led_o <= next_led;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    colour_3g_a: assert property (clk_en_i && is_3g |=> led_o == 2'b01)
        else $error("3G standard not shown green");
    colour_sd_a: assert property (clk_en_i && is_sd |=> led_o.red && !led_o.green)
        else $error("SD standard not shown red");
    colour_off_a: assert property (clk_en_i && !std_i.std_valid |=> led_o == 2'b00)
        else $error("LED lit without detected standard");
endmodule

/* File: hw/ssl_pkg.sv */
// Shared constants and types of the status LED selector
package ssl_pkg;
    // Register offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] STATE_OFS = 8'h0C;

    // Event bits of status and mask
    localparam int unsigned EV_P1_STD = 0;
    localparam int unsigned EV_P2_STD = 1;
    localparam int unsigned EV_P1_UNALIGN = 2;
    localparam int unsigned EV_P2_UNALIGN = 3;
    localparam int unsigned EV_PATTERN = 4;
    localparam int unsigned EV_W = 5;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h00;

    // Field positions
    localparam int unsigned CTRL_PAT_LSB = 0;
    localparam int unsigned STATE_LED_LSB = 0;
    localparam int unsigned STATE_VIEW_LSB = 4;
    localparam int unsigned STATE_PAT_LSB = 6;

    // Signal standard codes
    localparam logic [1:0] STD_SD = 2'h0;
    localparam logic [1:0] STD_HD = 2'h1;
    localparam logic [1:0] STD_3G = 2'h3;

    // LED view selector codes
    localparam logic [1:0] VIEW_P1 = 2'h0;
    localparam logic [1:0] VIEW_P2 = 2'h1;
    localparam logic [1:0] VIEW_STD = 2'h2;
    localparam logic [1:0] VIEW_TX = 2'h3;
    localparam logic [3:0] LED_RST = 4'h0;

    // SD clock strobe: average rate SD_CLK_KHZ out of SYS_CLK_KHZ
    localparam int unsigned SYS_CLK_KHZ = 125000;
    localparam int unsigned SD_CLK_KHZ = 27000;
    localparam logic [16:0] SD_ACC_STEP = 17'(SD_CLK_KHZ);
    localparam logic [16:0] SD_ACC_MOD = 17'(SYS_CLK_KHZ);

    typedef enum logic [1:0] {
        PAT_BAR75 = 2'b00,
        PAT_BAR100 = 2'b01,
        PAT_CHECK = 2'b10
    } ssl_pattern_type;
    localparam ssl_pattern_type PAT_RST = PAT_BAR75;

    typedef struct packed {
        logic aligned;
        logic line_stable;
        logic frame_stable;
        logic resetting;
        logic std_valid;
        logic [1:0] std;
    } ssl_rx_status_type;

    typedef struct packed {
        logic std_valid;
        logic [1:0] std;
    } ssl_std_type;

    typedef struct packed {
        logic red;
        logic green;
    } ssl_bicolour_type;
endpackage

/* File: hw/ssl_sd_clock_generator.sv */
// Optional 27 MHz rate strobe for standard-definition data
`timescale 1ns/1ps
module ssl_sd_clock_generator #(
    parameter bit ENABLE = 1'b1 // Build the generator when set
) (
    input wire logic clk_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic clk_en_i, // Freezes state while low
    output logic sd_strobe_o // One-cycle pulses at 27 MHz average
);
    generate
        if (ENABLE) begin : gen_on
            logic [16:0] acc;
            // Carry bit: the sum can pass 2**17 before it wraps
            wire logic [17:0] acc_sum = {1'b0, acc} + {1'b0, ssl_pkg::SD_ACC_STEP};
            wire logic wrap = acc_sum >= {1'b0, ssl_pkg::SD_ACC_MOD};
            wire logic [17:0] acc_left = acc_sum - {1'b0, ssl_pkg::SD_ACC_MOD};
            wire logic [16:0] next_acc = wrap ? acc_left[16:0] : acc_sum[16:0];
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    acc <= '0;
                    sd_strobe_o <= 1'b0;
                end else if (clk_en_i) begin
                    acc <= next_acc;
                    sd_strobe_o <= wrap;
                end
            end
            strobe_spaced_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
                clk_en_i && sd_strobe_o |=> !sd_strobe_o)
                else $error("SD strobe exceeds half the clock rate");
        end else begin : gen_off
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sd_strobe_o <= 1'b0;
                end else begin
                    sd_strobe_o <= 1'b0;
                end
            end
            strobe_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
                !sd_strobe_o)
                else $error("SD strobe active while generator omitted");
        end
    endgenerate
endmodule

/* File: hw/ssl_status_led_selector.sv */
// Status LED selector with pattern select and register port
`timescale 1ns/1ps
// Operation
// - View 01: D10 lit while port 2 receiver is word aligned.
// - View 01: D9 lit while port 2 line format is stable.
// - View 01: D8 lit while port 2 frame format is stable.
// - View 01: D7 lit while port 2 receiver is resetting.
// - View 00: D10..D7 show the same four port 1 receiver conditions.
// - View 11: D10, D9 show generator standard; D8, D7 unlit.
// - View 10: D10, D9 port 1 standard; D8, D7 port 2 standard.
// - D1 lights once port 2 receive standard is detected.
// - D3 lights once port 2 transmit standard is detected.
// - D5 lights once port 1 transmit standard is detected.
// - D6 lights once port 1 receive standard is detected.
// - After reset the generator outputs 75 percent colour bars.
// - Build option adds a 27 MHz generator for SD data, else omitted.
// - Standards coded 00 SD, 01 HD, 11 for 3G.
// - Port LEDs: green 3G, orange HD, red SD.
// - Full bar button selects 100 percent colour bars.
// - Checkfield button selects the pathological checkfield pattern unless a full bar press comes in the same cycle.
module ssl_status_led_selector #(
    parameter bit sd_clock_gen_enable = 1'b1 // Build the SD clock generator
) (
    input wire logic clk_i, // System clock, 125 MHz
    input wire logic reset_n_i, // Async reset, active low
    input wire logic clk_en_i, // Freezes all state while low
    input wire logic [1:0] led_view_select_i, // Switch pins, asynchronous
    input wire logic full_bar_button_n_i, // Push button pin, low when pressed
    input wire logic checkfield_button_n_i, // Push button pin, low when pressed
    input wire ssl_pkg::ssl_rx_status_type rx1_status_i, // Port 1 receiver status
    input wire ssl_pkg::ssl_rx_status_type rx2_status_i, // Port 2 receiver status
    input wire ssl_pkg::ssl_std_type tx1_std_i, // Port 1 transmit standard
    input wire ssl_pkg::ssl_std_type tx2_std_i, // Port 2 transmit standard
    input wire logic [7:0] reg_addr_i, // Register byte address
    input wire logic [31:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
    output logic irq_o, // Level interrupt, active high
    output logic [3:0] user_led_o, // Bit 3 D10, 2 D9, 1 D8, 0 D7
    output ssl_pkg::ssl_bicolour_type led_d1_o, // Port 2 receive standard
    output ssl_pkg::ssl_bicolour_type led_d3_o, // Port 2 transmit standard
    output ssl_pkg::ssl_bicolour_type led_d5_o, // Port 1 transmit standard
    output ssl_pkg::ssl_bicolour_type led_d6_o, // Port 1 receive standard
    output ssl_pkg::ssl_pattern_type pattern_select_o, // Generator pattern
    output logic sd_strobe_o // 27 MHz rate strobe for SD data
);
    // Pin synchronisers
    logic [1:0] view_meta;
    logic [1:0] view_q;
    logic [1:0] btn_meta;
    logic [1:0] btn_q;
    logic [1:0] btn_prev;

    // Edge detection history
    logic p1_valid_prev;
    logic p2_valid_prev;
    logic p1_aligned_prev;
    logic p2_aligned_prev;

    // Registers
    logic [ssl_pkg::EV_W-1:0] status;
    logic [ssl_pkg::EV_W-1:0] mask;
    ssl_pkg::ssl_pattern_type pattern;

    // Button presses, index 0 full bar, 1 checkfield
    wire logic [1:0] btn_press = btn_q & ~btn_prev;
    wire logic full_press = btn_press[0];
    wire logic check_press = btn_press[1];

    // Register decode
    wire logic sel_status = reg_addr_i == ssl_pkg::STATUS_OFS;
    wire logic sel_mask = reg_addr_i == ssl_pkg::MASK_OFS;
    wire logic sel_ctrl = reg_addr_i == ssl_pkg::CTRL_OFS;
    wire logic sel_state = reg_addr_i == ssl_pkg::STATE_OFS;
    wire logic wr_status = reg_wr_i && sel_status;
    wire logic wr_mask = reg_wr_i && sel_mask;
    wire logic [1:0] ctrl_pat = reg_wdata_i[ssl_pkg::CTRL_PAT_LSB +: 2];
    // Code 11 names no pattern and is ignored
    wire logic wr_ctrl = reg_wr_i && sel_ctrl && (ctrl_pat != 2'b11);

    // Pattern selection, buttons before software
    wire ssl_pkg::ssl_pattern_type next_pattern =
        full_press ? ssl_pkg::PAT_BAR100 :
        check_press ? ssl_pkg::PAT_CHECK :
        wr_ctrl ? ssl_pkg::ssl_pattern_type'(ctrl_pat) : pattern;

    // LED views
    wire logic [3:0] view_p1 = {rx1_status_i.aligned, rx1_status_i.line_stable,
        rx1_status_i.frame_stable, rx1_status_i.resetting};
    wire logic [3:0] view_p2 = {rx2_status_i.aligned, rx2_status_i.line_stable,
        rx2_status_i.frame_stable, rx2_status_i.resetting};
    wire logic [3:0] view_std = {rx1_status_i.std[0], rx1_status_i.std[1],
        rx2_status_i.std[0], rx2_status_i.std[1]};
    wire logic [3:0] view_tx = {tx1_std_i.std[0], tx1_std_i.std[1], 2'b00};
    wire logic [3:0] next_user_led =
        (view_q == ssl_pkg::VIEW_P1) ? view_p1 :
        (view_q == ssl_pkg::VIEW_P2) ? view_p2 :
        (view_q == ssl_pkg::VIEW_STD) ? view_std : view_tx;

    // Events and sticky status, a set beats a clear
    wire logic [ssl_pkg::EV_W-1:0] events = {
        next_pattern != pattern,
        p2_aligned_prev && !rx2_status_i.aligned,
        p1_aligned_prev && !rx1_status_i.aligned,
        rx2_status_i.std_valid && !p2_valid_prev,
        rx1_status_i.std_valid && !p1_valid_prev};
    wire logic [ssl_pkg::EV_W-1:0] clear_bits =
        wr_status ? reg_wdata_i[ssl_pkg::EV_W-1:0] : '0;
    wire logic [ssl_pkg::EV_W-1:0] next_status = (status & ~clear_bits) | events;
    wire logic [ssl_pkg::EV_W-1:0] next_mask =
        wr_mask ? reg_wdata_i[ssl_pkg::EV_W-1:0] : mask;
    wire logic next_irq = |(next_status & next_mask);

    // Read data
    wire logic [31:0] state_word = {24'h000000, pattern,
        view_q, user_led_o};
    wire logic [31:0] read_word =
        sel_status ? {27'h0000000, status} :
        sel_mask ? {27'h0000000, mask} :
        sel_ctrl ? {30'h00000000, pattern} :
        sel_state ? state_word : 32'h00000000;
    wire logic [31:0] next_rdata = reg_rd_i ? read_word : 32'h00000000;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            view_meta <= 2'h0;
            view_q <= 2'h0;
            btn_meta <= 2'h0;
            btn_q <= 2'h0;
            btn_prev <= 2'h0;
        end else if (clk_en_i) begin
            view_meta <= led_view_select_i;
            view_q <= view_meta;
            btn_meta <= {~checkfield_button_n_i, ~full_bar_button_n_i};
            btn_q <= btn_meta;
            btn_prev <= btn_q;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            p1_valid_prev <= 1'b0;
            p2_valid_prev <= 1'b0;
            p1_aligned_prev <= 1'b0;
            p2_aligned_prev <= 1'b0;
        end else if (clk_en_i) begin
            p1_valid_prev <= rx1_status_i.std_valid;
            p2_valid_prev <= rx2_status_i.std_valid;
            p1_aligned_prev <= rx1_status_i.aligned;
            p2_aligned_prev <= rx2_status_i.aligned;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_led_o <= ssl_pkg::LED_RST;
        end else if (clk_en_i) begin
            user_led_o <= next_user_led;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pattern <= ssl_pkg::PAT_RST;
        end else if (clk_en_i) begin
            pattern <= next_pattern;
        end
    end
    assign pattern_select_o = pattern;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status <= ssl_pkg::STATUS_RST;
            mask <= ssl_pkg::MASK_RST;
            irq_o <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end else if (clk_en_i) begin
            status <= next_status;
            mask <= next_mask;
            irq_o <= next_irq;
            reg_rdata_o <= next_rdata;
        end
    end

    // Receive standards as the port LEDs see them
    wire ssl_pkg::ssl_std_type rx1_std = {rx1_status_i.std_valid, rx1_status_i.std};
    wire ssl_pkg::ssl_std_type rx2_std = {rx2_status_i.std_valid, rx2_status_i.std};

    // Port standard LEDs
    ssl_bicolour_led u_led_d1 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .std_i(rx2_std),
        .led_o(led_d1_o)
    );

    ssl_bicolour_led u_led_d3 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .std_i(tx2_std_i),
        .led_o(led_d3_o)
    );

    ssl_bicolour_led u_led_d5 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .std_i(tx1_std_i),
        .led_o(led_d5_o)
    );

    ssl_bicolour_led u_led_d6 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .std_i(rx1_std),
        .led_o(led_d6_o)
    );

    ssl_sd_clock_generator #(
        .ENABLE(sd_clock_gen_enable)
    ) u_sd_clock_generator (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .sd_strobe_o(sd_strobe_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    p2_align_led_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_P2
        |=> user_led_o[3] == $past(rx2_status_i.aligned))
        else $error("D10 does not follow port 2 alignment");
    p2_line_led_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_P2
        |=> user_led_o[2] == $past(rx2_status_i.line_stable))
        else $error("D9 does not follow port 2 line format");
    p2_frame_led_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_P2
        |=> user_led_o[1] == $past(rx2_status_i.frame_stable))
        else $error("D8 does not follow port 2 frame format");
    p2_reset_led_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_P2
        |=> user_led_o[0] == $past(rx2_status_i.resetting))
        else $error("D7 does not follow port 2 reset");
    p1_view_leds_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_P1
        |=> user_led_o == $past(view_p1))
        else $error("Port 1 view shows wrong LEDs");
    tx_view_leds_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_TX
        |=> user_led_o == {$past(tx1_std_i.std[0]), $past(tx1_std_i.std[1]), 2'b00})
        else $error("Generator view shows wrong LEDs");
    std_view_leds_a: assert property (clk_en_i && view_q == ssl_pkg::VIEW_STD
        |=> user_led_o[3:2] == {$past(rx1_status_i.std[0]), $past(rx1_status_i.std[1])}
        && user_led_o[1:0] == {$past(rx2_status_i.std[0]), $past(rx2_status_i.std[1])})
        else $error("Standard view shows wrong LEDs");
    leds_frozen_a: assert property (!clk_en_i |=> $stable(user_led_o))
        else $error("LEDs changed with clock enable low");
    pattern_cause_a: assert property ($changed(pattern_select_o)
        |-> $past(clk_en_i && (full_press || check_press || wr_ctrl)))
        else $error("Pattern changed without a button or write");
    full_bar_sel_a: assert property (clk_en_i && full_press
        |=> pattern_select_o == ssl_pkg::PAT_BAR100)
        else $error("Full bar button ignored");
    checkfield_sel_a: assert property (clk_en_i && check_press && !full_press
        |=> pattern_select_o == ssl_pkg::PAT_CHECK)
        else $error("Checkfield button ignored");
    status_set_wins_a: assert property (clk_en_i && |events
        |=> (status & $past(events)) == $past(events))
        else $error("Status event lost");
    irq_level_a: assert property (irq_o == |(status & mask))
        else $error("Interrupt does not match status and mask");
    irq_masked_a: assert property (mask == '0 |-> !irq_o)
        else $error("Interrupt with all events masked");

    // Register port
    rdata_idle_a: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("Read data not zero outside a read");
    rdata_status_a: assert property (clk_en_i && reg_rd_i && sel_status
        |=> reg_rdata_o == {27'h0000000, $past(status)})
        else $error("Status read wrong");
    rdata_mask_a: assert property (clk_en_i && reg_rd_i && sel_mask
        |=> reg_rdata_o == {27'h0000000, $past(mask)})
        else $error("Mask read wrong");
    rdata_ctrl_a: assert property (clk_en_i && reg_rd_i && sel_ctrl
        |=> reg_rdata_o == {30'h00000000, $past(pattern)})
        else $error("Control read wrong");
    rdata_state_a: assert property (clk_en_i && reg_rd_i && sel_state
        |=> reg_rdata_o[5:4] == $past(view_q) && reg_rdata_o[3:0] == $past(user_led_o))
        else $error("State read wrong");
    rdata_unmapped_a: assert property (clk_en_i && reg_rd_i
        && !(sel_status || sel_mask || sel_ctrl || sel_state)
        |=> reg_rdata_o == 32'h00000000)
        else $error("Unmapped read not zero");
    mask_write_a: assert property (clk_en_i && wr_mask
        |=> mask == $past(reg_wdata_i[ssl_pkg::EV_W-1:0]))
        else $error("Mask write lost");

    // Sticky events
    status_clear_a: assert property (clk_en_i && wr_status
        |=> (status & $past(clear_bits & ~events)) == '0)
        else $error("Status bit not cleared");
    status_sticky_a: assert property (clk_en_i && !wr_status
        |=> (status & $past(status)) == $past(status))
        else $error("Status bit dropped");
    p1_std_event_a: assert property (clk_en_i && rx1_status_i.std_valid && !p1_valid_prev
        |=> status[ssl_pkg::EV_P1_STD])
        else $error("Port 1 detection not flagged");
    p2_std_event_a: assert property (clk_en_i && rx2_status_i.std_valid && !p2_valid_prev
        |=> status[ssl_pkg::EV_P2_STD])
        else $error("Port 2 detection not flagged");
    p1_unalign_event_a: assert property (clk_en_i && p1_aligned_prev && !rx1_status_i.aligned
        |=> status[ssl_pkg::EV_P1_UNALIGN])
        else $error("Port 1 alignment loss not flagged");
    p2_unalign_event_a: assert property (clk_en_i && p2_aligned_prev && !rx2_status_i.aligned
        |=> status[ssl_pkg::EV_P2_UNALIGN])
        else $error("Port 2 alignment loss not flagged");

    // Pattern control
    ctrl_illegal_a: assert property (clk_en_i && reg_wr_i && sel_ctrl && ctrl_pat == 2'b11
        && !full_press && !check_press |=> $stable(pattern_select_o))
        else $error("Pattern code 11 accepted");
    ctrl_write_a: assert property (clk_en_i && wr_ctrl && !full_press && !check_press
        |=> pattern_select_o == $past(ctrl_pat))
        else $error("Pattern write lost");
    pattern_legal_a: assert property (pattern_select_o != ssl_pkg::ssl_pattern_type'(2'b11))
        else $error("Pattern holds an unused code");

    // Nothing moves while the clock enable is low
    regs_frozen_a: assert property (!clk_en_i
        |=> $stable(status) && $stable(mask) && $stable(irq_o) && $stable(reg_rdata_o))
        else $error("Registers changed with clock enable low");
    pattern_frozen_a: assert property (!clk_en_i |=> $stable(pattern_select_o))
        else $error("Pattern changed with clock enable low");
    port_leds_frozen_a: assert property (!clk_en_i
        |=> $stable(led_d1_o) && $stable(led_d3_o) && $stable(led_d5_o) && $stable(led_d6_o))
        else $error("Port LEDs changed with clock enable low");
endmodule

/* File: verification/ssl_sdi_core_model.sv */
// Behavioural model of the receiver and transmitter core status outputs
`timescale 1ns/1ps
module ssl_sdi_core_model (
    input wire logic clk_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic [19:0] cmd_i, // Next rx1, rx2, tx1, tx2 words
    output ssl_pkg::ssl_rx_status_type rx1_o, // Port 1 receiver
    output ssl_pkg::ssl_rx_status_type rx2_o, // Port 2 receiver
    output ssl_pkg::ssl_std_type tx1_o, // Port 1 transmitter
    output ssl_pkg::ssl_std_type tx2_o // Port 2 transmitter
);
    // Registered like the cores, so the selector sees same-clock levels
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {rx1_o, rx2_o, tx1_o, tx2_o} <= 20'h00000;
        end else begin
            {rx1_o, rx2_o, tx1_o, tx2_o} <= cmd_i;
        end
    end
endmodule

/* File: verification/ssl_status_led_selector_tb.sv */
// Self-checking testbench of the status LED selector
`timescale 1ns/1ps
module ssl_status_led_selector_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] view = 2'h0;
    logic fb_n = 1'b1;
    logic cf_n = 1'b1;
    logic [19:0] cmd = 20'h00000;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic en = 1'b1;
    logic [3:0] held;
    logic [31:0] rdata;
    logic [31:0] r;
    logic irq;
    logic [3:0] led;
    logic sd;
    ssl_pkg::ssl_bicolour_type d1, d3, d5, d6;
    ssl_pkg::ssl_pattern_type pat;
    ssl_pkg::ssl_rx_status_type rx1, rx2;
    ssl_pkg::ssl_std_type tx1, tx2;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    integer seed = 49;
    int n_sd = 0;

    ssl_sdi_core_model core_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
        .rx1_o(rx1), .rx2_o(rx2), .tx1_o(tx1), .tx2_o(tx2)
    );

    ssl_status_led_selector #(.sd_clock_gen_enable(1'b1)) dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
        .led_view_select_i(view), .full_bar_button_n_i(fb_n),
        .checkfield_button_n_i(cf_n), .rx1_status_i(rx1), .rx2_status_i(rx2),
        .tx1_std_i(tx1), .tx2_std_i(tx2), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
        .user_led_o(led), .led_d1_o(d1), .led_d3_o(d3), .led_d5_o(d5),
        .led_d6_o(d6), .pattern_select_o(pat), .sd_strobe_o(sd)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected user LEDs {D10, D9, D8, D7} for a view and a core status word
    function automatic logic [3:0] exp_led(input logic [1:0] v, input logic [19:0] c);
        ssl_pkg::ssl_rx_status_type a;
        ssl_pkg::ssl_rx_status_type b;
        ssl_pkg::ssl_std_type t;
        {a, b, t} = c[19:3];
        case (v)
            ssl_pkg::VIEW_P1: exp_led = {a.aligned, a.line_stable, a.frame_stable, a.resetting};
            ssl_pkg::VIEW_P2: exp_led = {b.aligned, b.line_stable, b.frame_stable, b.resetting};
            ssl_pkg::VIEW_STD: exp_led = {a.std[0], a.std[1], b.std[0], b.std[1]};
            default: exp_led = {t.std[0], t.std[1], 2'b00};
        endcase
    endfunction

    // Red for SD or HD, green for HD or 3G, dark when invalid or code 10
    function automatic logic [1:0] exp_bic(input logic [2:0] s);
        exp_bic = {s[2] & ~s[1], s[2] & s[0]};
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic press(input bit full);
        @(posedge clk_i);
        if (full) begin
            fb_n <= 1'b0;
        end else begin
            cf_n <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        fb_n <= 1'b1;
        cf_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        check(pat, ssl_pkg::PAT_BAR75);
        check(irq, 1'b0);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_i);
            view <= v[1:0];
            for (int k = 0; k < 12; k++) begin
                @(posedge clk_i);
                cmd <= (k == 0) ? 20'hFFFFF : 20'($random(seed));
                repeat (5) @(posedge clk_i);
                #1;
                check(led, exp_led(v[1:0], cmd));
                check(d1, exp_bic(cmd[8:6]));
                check(d3, exp_bic(cmd[2:0]));
                check(d5, exp_bic(cmd[5:3]));
                check(d6, exp_bic(cmd[15:13]));
            end
        end
        @(posedge clk_i);
        cmd <= 20'h00000;
        repeat (4) @(posedge clk_i);
        reg_wr(ssl_pkg::STATUS_OFS, 32'h0000001F);
        reg_rd(ssl_pkg::STATUS_OFS, r);
        check(r, 32'h00000000);
        reg_rd(8'h10, r);
        check(r, 32'h00000000);
        press(1'b1);
        check(pat, ssl_pkg::PAT_BAR100);
        check(irq, 1'b0);
        reg_rd(ssl_pkg::STATUS_OFS, r);
        check(r, 32'h00000010);
        reg_wr(ssl_pkg::MASK_OFS, 32'h00000010);
        check(irq, 1'b1);
        reg_wr(ssl_pkg::STATUS_OFS, 32'h00000010);
        check(irq, 1'b0);
        press(1'b0);
        check(pat, ssl_pkg::PAT_CHECK);
        check(irq, 1'b1);
        reg_wr(ssl_pkg::CTRL_OFS, 32'h00000003);
        reg_rd(ssl_pkg::CTRL_OFS, r);
        check(r, 32'h00000002);
        reg_wr(ssl_pkg::CTRL_OFS, 32'h00000000);
        check(pat, ssl_pkg::PAT_BAR75);
        reg_wr(ssl_pkg::STATUS_OFS, 32'h0000001F);
        @(posedge clk_i);
        cmd <= 20'h08100;
        repeat (4) @(posedge clk_i);
        reg_rd(ssl_pkg::STATUS_OFS, r);
        check(r, 32'h00000003);
        // Clock enable low: LEDs hold and a mask write is ignored
        held = led;
        @(posedge clk_i);
        en <= 1'b0;
        cmd <= ~cmd;
        reg_wr(ssl_pkg::MASK_OFS, 32'h0000000F);
        repeat (3) @(posedge clk_i);
        #1;
        check(led, held);
        @(posedge clk_i);
        en <= 1'b1;
        reg_rd(ssl_pkg::MASK_OFS, r);
        check(r, 32'h00000010);
        reg_rd(ssl_pkg::STATE_OFS, r);
        check(r, {24'h000000, ssl_pkg::PAT_BAR75, 2'b11, exp_led(2'b11, cmd)});
        repeat (1250) begin
            @(posedge clk_i);
            #1;
            n_sd += int'(sd);
        end
        check((n_sd > 268 && n_sd < 272) ? 32'h1 : 32'h0, 32'h1);
        finish_test();
    end
endmodule
